// ==== hdl/rcl_reset_config_latch.sv ====
// reset-release capture of data bus configuration levels
//
// Contract
// - capture configuration pin levels at the rising edge of reset and apply them.
// - data pins have weak pull-ups; undriven pins read as one.
// - captured high selects default function, captured low selects alternate.
// - data bit 0 high gives 16-bit boot select, low gives 8-bit.
// - data bit 1 high gives chip selects 0-2, low gives bus arbitration pins.
// - bits 3-7 low run from bit 3 turns chip selects into address lines.
// - data bit 8 low moves bus control pins to port E.
// - software may override reset-chosen pin functions afterwards.
// - data bit 9 low moves interrupt pins to port F.
// - clock-mode pin high selects synthesiser, low selects crystal input.
// - breakpoint pin captured each reset release; low enables background debug.
`timescale 1ns/100ps
`default_nettype none
module rcl_reset_config_latch
  import rcl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              resetPinN,
  input  wire logic [DATA_W-1:0] dataBusIn,
  input  wire logic              clockSourceSelect,
  input  wire logic              breakpointInN,
  input  wire logic              swOverrideEn,
  input  wire logic              swBootByteWide,
  input  wire logic              swBusArbitration,
  input  wire logic              swFunctionCodeOut,
  input  wire logic [4:0]        swAddrSelect,
  input  wire logic              swPortEIo,
  input  wire logic              swPortFIo,
  output logic                   bootChipSelect16,
  output logic                   busArbitrationEn,
  output logic                   functionCodeOutEn,
  output logic [4:0]             addrLineEn,
  output logic                   portEIoEn,
  output logic                   portFIoEn,
  output logic                   factorySlaveMode,
  output logic                   synthOscillatorClk,
  output logic                   backgroundDebugEn,
  output logic                   configValid
);
  logic [DATA_W-1:0] dataS;
  logic              resetS;
  logic              clkSelS;
  logic              bkptS;
  logic              resetPrev_q;
  logic [DATA_W-1:0] cap_q;
  logic              capClk_q;
  logic              capBkpt_q;
  logic              captured_q;
  logic [4:0]        thermo;
  logic              releaseEdge;

  rcl_sync2 #(.W(DATA_W + 3), .INI('1)) uSync (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .din  ({dataBusIn, resetPinN, clockSourceSelect, breakpointInN}),
    .dout ({dataS, resetS, clkSelS, bkptS})
  );

  assign releaseEdge = resetS & ~resetPrev_q;

  // contiguous low run from bit 3
  assign thermo[0] = ~cap_q[BIT_ADDR_LO];
  genvar gi;
  generate
    for (gi = 1; gi < ADDR_SEL_W; gi++)
    begin : g_th
      assign thermo[gi] = thermo[gi-1] & ~cap_q[BIT_ADDR_LO+gi];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      // reset pin idles high, no false edge
      resetPrev_q <= 1'b1;
      cap_q       <= DATA_RESET;
      capClk_q    <= 1'b1;
      capBkpt_q   <= 1'b1;
      captured_q  <= 1'b0;
    end
    else if (ce)
    begin
      resetPrev_q <= resetS;
      if (releaseEdge)
      begin
        cap_q      <= dataS;
        capClk_q   <= clkSelS;
        capBkpt_q  <= bkptS;
        captured_q <= 1'b1;
      end
    end
  end

  wire useSw = swOverrideEn & captured_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bootChipSelect16   <= 1'b1;
      busArbitrationEn   <= 1'b0;
      functionCodeOutEn  <= 1'b0;
      addrLineEn         <= ADDR_RESET;
      portEIoEn          <= 1'b0;
      portFIoEn          <= 1'b0;
      factorySlaveMode   <= 1'b0;
      synthOscillatorClk <= 1'b1;
      backgroundDebugEn  <= 1'b0;
      configValid        <= 1'b0;
    end
    else if (ce)
    begin
      bootChipSelect16   <= useSw ? ~swBootByteWide : cap_q[BIT_BOOT_W];
      busArbitrationEn   <= useSw ? swBusArbitration : ~cap_q[BIT_ARB];
      functionCodeOutEn  <= useSw ? swFunctionCodeOut : ~cap_q[BIT_FC];
      addrLineEn         <= useSw ? swAddrSelect : thermo;
      portEIoEn          <= useSw ? swPortEIo : ~cap_q[BIT_PORT_E];
      portFIoEn          <= useSw ? swPortFIo : ~cap_q[BIT_PORT_F];
      // slave mode only if driven low
      factorySlaveMode   <= captured_q & ~cap_q[BIT_FACTORY];
      synthOscillatorClk <= capClk_q;
      backgroundDebugEn  <= captured_q & ~capBkpt_q;
      configValid        <= captured_q;
    end
  end

  // assertions
  property p_capture;
    @(posedge clk) disable iff (!rstn)
      (ce && releaseEdge) |=> (cap_q == $past(dataS));
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

  property p_hold;
    @(posedge clk) disable iff (!rstn)
      (!releaseEdge) |=> (cap_q == $past(cap_q));
  endproperty
  a_hold: assert property (p_hold) else $error("config changed");

  property p_boot;
    @(posedge clk) disable iff (!rstn)
      (ce && !useSw) |=> (bootChipSelect16 == $past(cap_q[BIT_BOOT_W]));
  endproperty
  a_boot: assert property (p_boot) else $error("boot width wrong");

  property p_arb;
    @(posedge clk) disable iff (!rstn)
      (ce && !useSw) |=> (busArbitrationEn == !$past(cap_q[BIT_ARB]));
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration wrong");

  property p_fc;
    @(posedge clk) disable iff (!rstn)
      (ce && !useSw) |=> (functionCodeOutEn == !$past(cap_q[BIT_FC]));
  endproperty
  a_fc: assert property (p_fc) else $error("function code wrong");

  property p_thermo;
    @(posedge clk) disable iff (!rstn)
      (ce && !useSw && cap_q[7:3] == 5'h00) |=> (addrLineEn == 5'h1f);
  endproperty
  a_thermo: assert property (p_thermo) else $error("address select wrong");

  property p_port_e_io;
    @(posedge clk) disable iff (!rstn)
      (ce && !useSw) |=> (portEIoEn == !$past(cap_q[BIT_PORT_E]));
  endproperty
  a_port_e_io: assert property (p_port_e_io) else $error("port e wrong");

  property p_port_f_io;
    @(posedge clk) disable iff (!rstn)
      (ce && !useSw) |=> (portFIoEn == !$past(cap_q[BIT_PORT_F]));
  endproperty
  a_port_f_io: assert property (p_port_f_io) else $error("port f wrong");

  property p_clk;
    @(posedge clk) disable iff (!rstn)
      ce |=> (synthOscillatorClk == $past(capClk_q));
  endproperty
  a_clk: assert property (p_clk) else $error("clock select wrong");

  sequence s_rel;
    ce && releaseEdge && !bkptS;
  endsequence
  property p_bdm;
    @(posedge clk) disable iff (!rstn)
      s_rel ##1 ce |=> backgroundDebugEn;
  endproperty
  a_bdm: assert property (p_bdm) else $error("debug not enabled");

  sequence s_rel_off;
    ce && releaseEdge && bkptS;
  endsequence
  property p_bdm_off;
    @(posedge clk) disable iff (!rstn)
      s_rel_off ##1 ce |=> !backgroundDebugEn;
  endproperty
  a_bdm_off: assert property (p_bdm_off) else $error("debug not disabled");

  property p_sw;
    @(posedge clk) disable iff (!rstn)
      (ce && useSw) |=> (portEIoEn == $past(swPortEIo));
  endproperty
  a_sw: assert property (p_sw) else $error("override ignored");
endmodule
`default_nettype wire

// ==== hdl/rcl_pkg.sv ====
// constants for the reset configuration pin latch
package rcl_pkg;
  localparam int          DATA_W        = 16;
  localparam int          BIT_BOOT_W    = 0;
  localparam int          BIT_ARB       = 1;
  localparam int          BIT_FC        = 2;
  localparam int          BIT_ADDR_LO   = 3;
  localparam int          ADDR_SEL_W    = 5;
  localparam int          BIT_PORT_E    = 8;
  localparam int          BIT_PORT_F    = 9;
  localparam int          BIT_FACTORY   = 11;
  localparam logic [15:0] DATA_RESET    = 16'hffff;
  localparam logic [4:0]  ADDR_RESET    = 5'h00;
endpackage

// ==== hdl/rcl_sync2.sv ====
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
`default_nettype none
module rcl_sync2 #(
  parameter int          W   = 1,
  parameter logic [W-1:0] INI = '1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_q <= INI;
      dout   <= INI;
    end
    else if (ce)
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== verification/rcl_cfg_drv.sv ====
// reset-time configuration driver on a pulled-up data bus
`timescale 1ns/100ps
`default_nettype none
module rcl_cfg_drv
(
  input  wire logic        clk,
  input  wire logic        resetPinN,
  input  wire logic        dataStrobeHi,
  input  wire logic        readHi,
  input  wire logic [15:0] cfgLevel,
  output logic      [15:0] busLevel
);
  logic [2:0] holdCnt = 3'h0;
  // enable only reset low, strobe high, read
  wire logic gateOn = !resetPinN && dataStrobeHi && readHi;
  // buffer turn-off delay gives the hold time
  always @(posedge clk)
    holdCnt <= gateOn ? 3'h6 : (holdCnt != 3'h0 ? holdCnt - 3'h1 : 3'h0);
  // pull-ups when off, factory bit high
  assign busLevel = (gateOn || holdCnt != 3'h0) ? (cfgLevel | 16'h0800) : 16'hffff;
endmodule
`default_nettype wire

// ==== verification/reset_config_pin_latch_tb_top.sv ====
// bench for the reset configuration pin latch
`timescale 1ns/100ps
`default_nettype none
module reset_config_pin_latch_tb_top;
  import rcl_pkg::*;
  logic        clk = 0, rstn = 0, rp = 1, ds = 1, rw = 1, mclk = 1, bkN = 1;
  logic        swEn = 0, swB = 0, swA = 0, swF = 0, swE = 0, swP = 0;
  logic [4:0]  swAd = 5'h00;
  logic [15:0] cfg = 16'hffff;
  logic [15:0] bus;
  wire logic [13:0] got;
  logic [13:0] keep;
  int          err_total = 0, cmp_count = 0, cycles = 0;
  logic [15:0] pats [13] = '{16'hffff, 16'h0000, 16'hfffe, 16'hfffd, 16'hfffb, 16'hfff7, 16'hffe7,
                            16'hffc7, 16'hff87, 16'hff07, 16'hffef, 16'hfeff, 16'hfdff};
  rcl_cfg_drv drv (.clk(clk), .resetPinN(rp), .dataStrobeHi(ds), .readHi(rw), .cfgLevel(cfg), .busLevel(bus));
  rcl_reset_config_latch dut (.clk(clk), .rstn(rstn), .ce(1'b1), .resetPinN(rp), .dataBusIn(bus),
    .clockSourceSelect(mclk), .breakpointInN(bkN), .swOverrideEn(swEn), .swBootByteWide(swB),
    .swBusArbitration(swA), .swFunctionCodeOut(swF), .swAddrSelect(swAd), .swPortEIo(swE),
    .swPortFIo(swP), .bootChipSelect16(got[13]), .busArbitrationEn(got[12]), .functionCodeOutEn(got[11]),
    .addrLineEn(got[10:6]), .portEIoEn(got[5]), .portFIoEn(got[4]), .factorySlaveMode(got[3]),
    .synthOscillatorClk(got[2]), .backgroundDebugEn(got[1]), .configValid(got[0]));
  initial
  begin
    forever #10 clk = ~clk;
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(string n, logic [13:0] e, logic [13:0] g);
    cmp_count++;
    if (e !== g)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [13:0] ev(logic [15:0] d, logic m, logic b);
    logic [4:0] a;
    a[0] = ~d[3];
    for (int i = 1; i < 5; i++) a[i] = a[i-1] & ~d[3+i];
    // slave mode off: partner holds bit 11 high
    return {d[0], ~d[1], ~d[2], a, ~d[8], ~d[9], 1'b0, m, ~b, 1'b1};
  endfunction
  task automatic cap(logic [15:0] d, logic m, logic b, logic w);
    cfg = d;
    mclk = m;
    bkN = b;
    rw = w;
    rp = 0;
    tick(4);
    rp = 1;
    tick(10);
  endtask
  task automatic t_table();
    for (int i = 0; i < 13; i++)
    begin
      cap(pats[i], i[0], i[1], 1'b1);
      chk("capture", ev(pats[i], i[0], i[1]), got);
    end
  endtask
  task automatic t_hold();
    cap(16'h0000, 1'b0, 1'b0, 1'b1);
    mclk = 1;
    bkN = 1;
    tick(8);
    chk("hold", ev(16'h0000, 1'b0, 1'b0), got);
  endtask
  task automatic t_over();
    keep = got;
    {swEn, swB, swA, swF, swAd, swE, swP} = {1'b1, 1'b0, 1'b0, 1'b0, 5'h0b, 1'b0, 1'b0};
    tick(3);
    chk("override", {1'b1, 1'b0, 1'b0, 5'h0b, 1'b0, 1'b0, keep[3:0]}, got);
    swEn = 0;
    tick(3);
    chk("override off", keep, got);
  endtask
  task automatic t_gate();
    ds = 0;
    cap(16'h0000, 1'b1, 1'b1, 1'b1);
    chk("strobe gated", ev(16'hffff, 1'b1, 1'b1), got);
    ds = 1;
    cap(16'h0000, 1'b1, 1'b1, 1'b0);
    chk("write gated", ev(16'hffff, 1'b1, 1'b1), got);
  endtask
  task automatic t_rst();
    rstn = 0;
    tick(2);
    rstn = 1;
    tick(2);
    chk("reset again", 14'h2004, got);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_total++;
      give_verdict();
    end
  end
  initial
  begin
    tick(6);
    rstn = 1;
    tick(2);
    chk("reset", 14'h2004, got);
    t_table();
    t_hold();
    t_over();
    t_gate();
    t_rst();
    give_verdict();
  end
endmodule
`default_nettype wire
